// *** ddr_pkg.sv ***
package ddr_pkg;
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_DES = 4'h1,
		CMD_MODE_SET = 4'h2,
		CMD_REF = 4'h3,
		CMD_SR_ENTER = 4'h4,
		CMD_SR_EXIT = 4'h5,
		CMD_PRE = 4'h6,
		CMD_PRE_ALL = 4'h7,
		CMD_ACT = 4'h8,
		CMD_WR = 4'h9,
		CMD_RD = 4'hA,
		CMD_ZQ = 4'hB,
		CMD_ILL = 4'hF
	} cmd_e;
	localparam int AW = 15;
	localparam int BAW = 3;
	localparam int DQW = 16;
	localparam int LANE_W = 8;
	localparam logic [2:0] MR_SEL_ZERO = 3'h0;
	localparam logic [2:0] MR_SEL_THREE = 3'h3;
	localparam logic [1:0] MODE0_BL_FIXED8 = 2'h0;
	localparam logic [1:0] MODE0_BL_FLY = 2'h1;
	localparam logic [1:0] MODE0_BL_FIXED4 = 2'h2;
	localparam int MODE0_BL_LSB = 0;
	localparam int MODE3_CAL_BIT = 2;
	localparam int MODE3_LOC_LSB = 0;
	localparam logic [1:0] LOC_PATTERN = 2'h0;
	localparam int AUTO_CLOSE_BIT = 10;
	localparam int CHOP_SELECT_BIT = 12;
	localparam int NIBBLE_BIT = 2;
	localparam logic [7:0] CAL_PATTERN = 8'hAA;
	localparam logic RESERVED_FILL = 1'b0;
	localparam logic [3:0] BEATS_FULL = 4'h8;
	localparam logic [3:0] BEATS_CHOP = 4'h4;
	localparam logic [2:0] CHOP_UPPER_START = 3'h4;
	localparam logic [3:0] READ_LATENCY = 4'h5;
	localparam int CLK_PERIOD_NS = 20;
	localparam int CMD_GAP_NS = 30;
	localparam logic [3:0] CMD_GAP_CYCLES = 4'((CMD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int DLL_LOCK_NS = 10240;
	localparam logic [9:0] DLL_LOCK_CYCLES = 10'((DLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_RDATA = 4'hC;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BA_LSB = 4;
	localparam int ST_BUSY = 0;
	localparam int ST_DLL = 1;
	localparam int ST_CAL = 2;
	localparam int ST_SELF_REF = 3;
	localparam int ST_REFUSED = 4;
endpackage : ddr_pkg

// *** ddr_link_if.sv ***
`timescale 1ns/1ps
interface ddr_link_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [ddr_pkg::BAW-1:0] ba;
	logic [ddr_pkg::AW-1:0] addr;
	logic [ddr_pkg::DQW-1:0] dq_dev;
	logic dq_dev_oe;
	logic [ddr_pkg::DQW-1:0] dq;
	// Wire level seen by the controller
	assign dq = dq_dev_oe ? dq_dev : 16'h0000;
	modport dev (
		input cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		output dq_dev, dq_dev_oe
	);
	modport ctl (
		output cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		input dq, dq_dev_oe
	);
endinterface : ddr_link_if

// *** cmd_decode.sv ***
`timescale 1ns/1ps
module cmd_decode (
	input wire logic cke_prev_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic auto_close_i,
	output ddr_pkg::cmd_e cmd_o
);
	logic [2:0] rcw;
	assign rcw = {ras_n_i, cas_n_i, we_n_i};
	always_comb begin
		cmd_o = ddr_pkg::CMD_ILL;
		if (!cke_prev_i && cke_i) begin
			// Exit needs deselect or no-operation
			cmd_o = (cs_n_i || rcw == 3'h7) ? ddr_pkg::CMD_SR_EXIT : ddr_pkg::CMD_ILL;
		end else if (cke_prev_i && !cke_i) begin
			cmd_o = (!cs_n_i && rcw == 3'h1) ? ddr_pkg::CMD_SR_ENTER : ddr_pkg::CMD_ILL;
		end else if (!cke_prev_i) begin
			cmd_o = ddr_pkg::CMD_NOP;
		end else if (cs_n_i) begin
			cmd_o = ddr_pkg::CMD_DES;
		end else begin
			case (rcw)
				3'h0: cmd_o = ddr_pkg::CMD_MODE_SET;
				3'h1: cmd_o = ddr_pkg::CMD_REF;
				3'h2: cmd_o = auto_close_i ? ddr_pkg::CMD_PRE_ALL : ddr_pkg::CMD_PRE;
				3'h3: cmd_o = ddr_pkg::CMD_ACT;
				3'h4: cmd_o = ddr_pkg::CMD_WR;
				3'h5: cmd_o = ddr_pkg::CMD_RD;
				3'h6: cmd_o = ddr_pkg::CMD_ZQ;
				3'h7: cmd_o = ddr_pkg::CMD_NOP;
				default: cmd_o = ddr_pkg::CMD_ILL;
			endcase
		end
	end
endmodule : cmd_decode

// *** ddr_device_end.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Pattern location, full burst: beats 0..7 alternating
// - Chop reads: nibble bit picks beats 0-3/4-7
// - Beat 0 is LSB, beat 7 MSB
// - Pattern is one-bit stream on all pins
// - Bit 0 of both lanes drives pattern
// - Lane bits 7..1 mirror bit 0 or zero
// - Controller zeroes column bits 1:0 on pattern reads
// - Controller zeroes nibble bit on full pattern reads
// - Bank, column 9:3, high bits other than the chop select bit ignored
// - Chop select bit picks chop when fly-enabled
// - Pattern reads keep ordinary read latency
// - Controller refuses pattern reads before lock
// - Controller keeps command spacing around mode changes
// - Write decode, column on low address bits
// - Fly write, chop bit low: four beats
// - Fly write, chop bit high: eight beats
// - Mode set, refresh, row open decodes
// - Precharge one/all, self-refresh entry decode
// - Commands decoded from strobes at rising edge
// - Mode register three bit 2 redirects reads
// - Auto-close ignored in pattern mode
// - Self-refresh exit on clock enable high
module ddr_device_end #(
	parameter logic [3:0] READ_LATENCY = ddr_pkg::READ_LATENCY,
	parameter bit MIRROR_LANES = 1'b1
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	ddr_link_if.dev link,
	input wire logic [ddr_pkg::DQW-1:0] array_data_i,
	output logic array_rd_o,
	output ddr_pkg::cmd_e cmd_o,
	output logic [ddr_pkg::BAW-1:0] bank_o,
	output logic [ddr_pkg::AW-1:0] addr_o,
	output logic [3:0] write_beats_o,
	output logic self_refresh_o,
	output logic cal_mode_o
);
	typedef enum logic {
		ST_AWAKE = 1'b0,
		ST_SLEEP = 1'b1
	} pwr_state_e;

	pwr_state_e state_reg;
	ddr_pkg::cmd_e dec_cmd;
	logic cke_prev_reg;
	logic [ddr_pkg::AW-1:0] mode0_reg;
	logic [ddr_pkg::AW-1:0] mode3_reg;
	logic pend_reg;
	logic [3:0] lat_cnt_reg;
	logic pend_cal_reg;
	logic pend_chop_reg;
	logic [2:0] pend_start_reg;
	logic [3:0] left_reg;
	logic [2:0] beat_reg;
	logic burst_cal_reg;
	logic [ddr_pkg::DQW-1:0] dq_reg;
	logic oe_reg;
	logic cal_on;
	logic chop_now;
	logic rd_take;
	logic burst_go;

	// Pattern bit per beat, placed on the data lanes
	function automatic logic [ddr_pkg::DQW-1:0] cal_word(
		input logic [1:0] loc,
		input logic [2:0] beat
	);
		logic b;
		b = (loc == ddr_pkg::LOC_PATTERN) ? ddr_pkg::CAL_PATTERN[beat] : ddr_pkg::RESERVED_FILL;
		if (MIRROR_LANES) begin
			cal_word = {ddr_pkg::DQW{b}};
		end else begin
			cal_word = {7'h00, b, 7'h00, b};
		end
	endfunction : cal_word

	// Chop decision from mode register zero and the chop select bit
	function automatic logic is_chop(
		input logic [1:0] bl,
		input logic sel
	);
		if (bl == ddr_pkg::MODE0_BL_FLY) begin
			is_chop = !sel;
		end else begin
			is_chop = (bl == ddr_pkg::MODE0_BL_FIXED4);
		end
	endfunction : is_chop

	cmd_decode i_cmd_decode (
		.cke_prev_i(cke_prev_reg),
		.cke_i(link.cke),
		.cs_n_i(link.cs_n),
		.ras_n_i(link.ras_n),
		.cas_n_i(link.cas_n),
		.we_n_i(link.we_n),
		.auto_close_i(link.addr[ddr_pkg::AUTO_CLOSE_BIT]),
		.cmd_o(dec_cmd)
	);

	assign cal_on = mode3_reg[ddr_pkg::MODE3_CAL_BIT];
	assign chop_now = is_chop(mode0_reg[ddr_pkg::MODE0_BL_LSB +: 2], link.addr[ddr_pkg::CHOP_SELECT_BIT]);
	// Auto-close bit is not decoded for reads, so read-with-close acts as read
	assign rd_take = (state_reg == ST_AWAKE) && (dec_cmd == ddr_pkg::CMD_RD) && !pend_reg;
	assign burst_go = pend_reg && (lat_cnt_reg == 4'h0);

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cke_prev_reg <= 1'b0;
		end else begin
			cke_prev_reg <= link.cke;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_AWAKE;
		end else begin
			case (state_reg)
				ST_AWAKE: begin
					if (dec_cmd == ddr_pkg::CMD_SR_ENTER) begin
						state_reg <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (dec_cmd == ddr_pkg::CMD_SR_EXIT) begin
						state_reg <= ST_AWAKE;
					end
				end
				default: state_reg <= ST_AWAKE;
			endcase
		end
	end

	// Mode registers, bank bits choose the target
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode0_reg <= 15'h0000;
			mode3_reg <= 15'h0000;
		end else if (state_reg == ST_AWAKE && dec_cmd == ddr_pkg::CMD_MODE_SET) begin
			if (link.ba == ddr_pkg::MR_SEL_ZERO) begin
				mode0_reg <= link.addr;
			end
			if (link.ba == ddr_pkg::MR_SEL_THREE) begin
				mode3_reg <= link.addr;
			end
		end
	end

	// Read command waits out the read latency
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pend_reg <= 1'b0;
			lat_cnt_reg <= 4'h0;
			pend_cal_reg <= 1'b0;
			pend_chop_reg <= 1'b0;
			pend_start_reg <= 3'h0;
		end else if (rd_take) begin
			pend_reg <= 1'b1;
			lat_cnt_reg <= READ_LATENCY - 4'h1;
			pend_cal_reg <= cal_on;
			pend_chop_reg <= chop_now;
			// Only the nibble bit steers order; chop select bit sets length, others unused
			pend_start_reg <= (chop_now && link.addr[ddr_pkg::NIBBLE_BIT]) ? ddr_pkg::CHOP_UPPER_START : 3'h0;
		end else if (burst_go) begin
			pend_reg <= 1'b0;
		end else if (pend_reg) begin
			lat_cnt_reg <= lat_cnt_reg - 4'h1;
		end
	end

	// Burst beats in fixed order from the start beat
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			left_reg <= 4'h0;
			beat_reg <= 3'h0;
			burst_cal_reg <= 1'b0;
		end else if (burst_go) begin
			left_reg <= pend_chop_reg ? ddr_pkg::BEATS_CHOP : ddr_pkg::BEATS_FULL;
			beat_reg <= pend_start_reg;
			burst_cal_reg <= pend_cal_reg;
		end else if (left_reg != 4'h0) begin
			left_reg <= left_reg - 4'h1;
			beat_reg <= beat_reg + 3'h1;
		end
	end

	assign array_rd_o = (left_reg != 4'h0) && !burst_cal_reg;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dq_reg <= 16'h0000;
			oe_reg <= 1'b0;
		end else if (left_reg != 4'h0) begin
			oe_reg <= 1'b1;
			if (burst_cal_reg) begin
				dq_reg <= cal_word(mode3_reg[ddr_pkg::MODE3_LOC_LSB +: 2], beat_reg);
			end else begin
				dq_reg <= array_data_i;
			end
		end else begin
			oe_reg <= 1'b0;
			dq_reg <= 16'h0000;
		end
	end

	assign link.dq_dev = dq_reg;
	assign link.dq_dev_oe = oe_reg;

	// Decoded command and its address seen by the user side
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_o <= ddr_pkg::CMD_NOP;
			bank_o <= 3'h0;
			addr_o <= 15'h0000;
		end else begin
			cmd_o <= dec_cmd;
			bank_o <= link.ba;
			// Column on low bits for writes, row for activate
			addr_o <= link.addr;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			write_beats_o <= 4'h0;
		end else if (state_reg == ST_AWAKE && dec_cmd == ddr_pkg::CMD_WR) begin
			write_beats_o <= chop_now ? ddr_pkg::BEATS_CHOP : ddr_pkg::BEATS_FULL;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			self_refresh_o <= 1'b0;
			cal_mode_o <= 1'b0;
		end else begin
			self_refresh_o <= (state_reg == ST_SLEEP);
			cal_mode_o <= cal_on;
		end
	end
endmodule : ddr_device_end

// *** ddr_ctrl_end.sv ***
`timescale 1ns/1ps
module ddr_ctrl_end (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	ddr_link_if.ctl link,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o
);
	ddr_pkg::cmd_e op;
	logic [2:0] op_ba;
	logic [ddr_pkg::AW-1:0] addr_reg;
	logic [ddr_pkg::AW-1:0] send_addr;
	logic [4:0] pins_reg;
	logic [ddr_pkg::BAW-1:0] ba_reg;
	logic [ddr_pkg::AW-1:0] out_addr_reg;
	logic [3:0] gap_reg;
	logic [9:0] dll_reg;
	logic dll_ready;
	logic sr_reg;
	logic cal_reg;
	logic [1:0] bl_reg;
	logic launch;
	logic refuse;
	logic accept;
	logic chop;
	logic refused_reg;
	logic [7:0] cap_reg;
	logic [2:0] cap_idx_reg;
	logic [3:0] cap_left_reg;

	// Pin pattern {cke, cs_n, ras_n, cas_n, we_n} for a command
	function automatic logic [4:0] pins_of(input ddr_pkg::cmd_e c);
		case (c)
			ddr_pkg::CMD_MODE_SET: pins_of = 5'h10;
			ddr_pkg::CMD_REF: pins_of = 5'h11;
			ddr_pkg::CMD_SR_ENTER: pins_of = 5'h01;
			ddr_pkg::CMD_PRE: pins_of = 5'h12;
			ddr_pkg::CMD_PRE_ALL: pins_of = 5'h12;
			ddr_pkg::CMD_ACT: pins_of = 5'h13;
			ddr_pkg::CMD_WR: pins_of = 5'h14;
			ddr_pkg::CMD_RD: pins_of = 5'h15;
			ddr_pkg::CMD_ZQ: pins_of = 5'h16;
			default: pins_of = 5'h17;
		endcase
	endfunction : pins_of

	assign op = ddr_pkg::cmd_e'(reg_wdata_i[ddr_pkg::CMD_OP_LSB +: 4]);
	assign op_ba = reg_wdata_i[ddr_pkg::CMD_BA_LSB +: 3];
	assign dll_ready = (dll_reg == 10'h000);
	assign launch = reg_wr_i && reg_addr_i == ddr_pkg::REG_CMD;
	assign chop = (bl_reg == ddr_pkg::MODE0_BL_FLY) ? !addr_reg[ddr_pkg::CHOP_SELECT_BIT]
		: (bl_reg == ddr_pkg::MODE0_BL_FIXED4);
	assign refuse = (gap_reg != 4'h0)
		|| (cal_reg && op != ddr_pkg::CMD_RD && op != ddr_pkg::CMD_MODE_SET)
		|| (cal_reg && op == ddr_pkg::CMD_RD && !dll_ready)
		|| (sr_reg != (op == ddr_pkg::CMD_SR_EXIT));
	assign accept = launch && !refuse;

	always_comb begin
		send_addr = addr_reg;
		if (cal_reg && op == ddr_pkg::CMD_RD) begin
			send_addr[1:0] = 2'h0;
			if (!chop) begin
				send_addr[ddr_pkg::NIBBLE_BIT] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			addr_reg <= 15'h0000;
		end else if (reg_wr_i && reg_addr_i == ddr_pkg::REG_ADDR) begin
			addr_reg <= reg_wdata_i[ddr_pkg::AW-1:0];
		end
	end

	// One command cycle, then no-operation or held low clock enable
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pins_reg <= 5'h17;
			ba_reg <= 3'h0;
			out_addr_reg <= 15'h0000;
		end else if (accept) begin
			pins_reg <= pins_of(op);
			ba_reg <= op_ba;
			out_addr_reg <= send_addr;
			if (op == ddr_pkg::CMD_PRE_ALL) begin
				out_addr_reg[ddr_pkg::AUTO_CLOSE_BIT] <= 1'b1;
			end
			if (op == ddr_pkg::CMD_PRE) begin
				out_addr_reg[ddr_pkg::AUTO_CLOSE_BIT] <= 1'b0;
			end
		end else begin
			pins_reg <= sr_reg ? 5'h0F : 5'h17;
		end
	end

	assign {link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n} = pins_reg;
	assign link.ba = ba_reg;
	assign link.addr = out_addr_reg;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap_reg <= 4'h0;
			dll_reg <= ddr_pkg::DLL_LOCK_CYCLES;
		end else begin
			if (accept) begin
				gap_reg <= ddr_pkg::CMD_GAP_CYCLES;
			end else if (gap_reg != 4'h0) begin
				gap_reg <= gap_reg - 4'h1;
			end
			if (!dll_ready) begin
				dll_reg <= dll_reg - 10'h001;
			end
		end
	end

	// Shadow of device mode state
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sr_reg <= 1'b0;
			cal_reg <= 1'b0;
			bl_reg <= ddr_pkg::MODE0_BL_FIXED8;
		end else if (accept) begin
			if (op == ddr_pkg::CMD_SR_ENTER) begin
				sr_reg <= 1'b1;
			end
			if (op == ddr_pkg::CMD_SR_EXIT) begin
				sr_reg <= 1'b0;
			end
			if (op == ddr_pkg::CMD_MODE_SET && op_ba == ddr_pkg::MR_SEL_THREE) begin
				cal_reg <= addr_reg[ddr_pkg::MODE3_CAL_BIT];
			end
			if (op == ddr_pkg::CMD_MODE_SET && op_ba == ddr_pkg::MR_SEL_ZERO) begin
				bl_reg <= addr_reg[ddr_pkg::MODE0_BL_LSB +: 2];
			end
		end
	end

	// Sticky refusal, a new refusal wins over the read clear
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			refused_reg <= 1'b0;
		end else if (launch && refuse) begin
			refused_reg <= 1'b1;
		end else if (reg_rd_i && reg_addr_i == ddr_pkg::REG_STATUS) begin
			refused_reg <= 1'b0;
		end
	end

	// Capture lane bit 0, beat n into bit n
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cap_reg <= 8'h00;
			cap_idx_reg <= 3'h0;
			cap_left_reg <= 4'h0;
		end else if (accept && op == ddr_pkg::CMD_RD) begin
			cap_reg <= 8'h00;
			cap_idx_reg <= (chop && send_addr[ddr_pkg::NIBBLE_BIT]) ? ddr_pkg::CHOP_UPPER_START : 3'h0;
			cap_left_reg <= chop ? ddr_pkg::BEATS_CHOP : ddr_pkg::BEATS_FULL;
		end else if (link.dq_dev_oe && cap_left_reg != 4'h0) begin
			cap_reg[cap_idx_reg] <= link.dq[0];
			cap_idx_reg <= cap_idx_reg + 3'h1;
			cap_left_reg <= cap_left_reg - 4'h1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ddr_pkg::REG_ADDR: reg_rdata_o <= {17'h00000, addr_reg};
				ddr_pkg::REG_STATUS: reg_rdata_o <= {27'h0000000, refused_reg, sr_reg, cal_reg, dll_ready,
					(gap_reg != 4'h0) || (cap_left_reg != 4'h0)};
				ddr_pkg::REG_RDATA: reg_rdata_o <= {24'h000000, cap_reg};
				default: reg_rdata_o <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end
endmodule : ddr_ctrl_end

// *** ddr_link_assertions.sv ***
`timescale 1ns/1ps
module ddr_link_assertions (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [ddr_pkg::BAW-1:0] ba,
	input wire logic [ddr_pkg::AW-1:0] addr,
	input wire logic [ddr_pkg::DQW-1:0] dq_dev,
	input wire logic dq_dev_oe
);
	logic is_cmd, is_rd, is_mrs, full_rd, rd_idle;
	logic cal_reg, full_pend_reg, up_pend_reg;
	logic [1:0] loc_reg, bl_reg;
	logic [3:0] since_rd_reg, beat_reg;
	logic [10:0] up_reg;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	assign is_cmd = cke && !cs_n && !(ras_n && cas_n && we_n);
	assign is_rd = is_cmd && ras_n && !cas_n && we_n;
	assign is_mrs = is_cmd && !ras_n && !cas_n && !we_n;
	assign full_rd = (bl_reg == ddr_pkg::MODE0_BL_FIXED8) || (bl_reg == ddr_pkg::MODE0_BL_FLY && addr[12]);
	assign rd_idle = is_rd && since_rd_reg == 4'hF;
	// Mode register shadows
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cal_reg <= 1'b0;
			loc_reg <= 2'h0;
			bl_reg <= 2'h0;
		end else if (is_mrs && ba == ddr_pkg::MR_SEL_THREE) begin
			cal_reg <= addr[2];
			loc_reg <= addr[1:0];
		end else if (is_mrs && ba == ddr_pkg::MR_SEL_ZERO) begin
			bl_reg <= addr[1:0];
		end
	end
	// Read bookkeeping
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			since_rd_reg <= 4'hF;
			full_pend_reg <= 1'b0;
			up_pend_reg <= 1'b0;
		end else if (is_rd) begin
			since_rd_reg <= 4'h0;
			full_pend_reg <= rd_idle ? full_rd : full_pend_reg;
			up_pend_reg <= rd_idle ? (!full_rd && addr[2]) : up_pend_reg;
		end else if (since_rd_reg != 4'hF) begin
			since_rd_reg <= since_rd_reg + 4'h1;
		end
	end
	// Beat index and time since reset
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			beat_reg <= 4'h0;
			up_reg <= 11'h000;
		end else begin
			beat_reg <= dq_dev_oe ? beat_reg + 4'h1 : 4'h0;
			up_reg <= (up_reg == 11'h7FF) ? up_reg : up_reg + 11'h001;
		end
	end
	a_lane_mirror: assert property (cal_reg && dq_dev_oe |-> dq_dev == {ddr_pkg::DQW{dq_dev[0]}})
		else $error("pattern not mirrored on all lanes");
	a_pattern_beat: assert property (cal_reg && loc_reg == ddr_pkg::LOC_PATTERN && dq_dev_oe
		|-> dq_dev[0] == ddr_pkg::CAL_PATTERN[beat_reg[2:0] | {up_pend_reg, 2'h0}])
		else $error("pattern beat wrong");
	a_reserved_fill: assert property (cal_reg && loc_reg != ddr_pkg::LOC_PATTERN && dq_dev_oe
		|-> dq_dev == {ddr_pkg::DQW{ddr_pkg::RESERVED_FILL}})
		else $error("reserved location data wrong");
	a_cal_low_bits: assert property (cal_reg && is_rd |-> addr[1:0] == 2'h0)
		else $error("pattern read with column bits set");
	a_cal_full_nibble: assert property (cal_reg && is_rd && full_rd |-> !addr[2])
		else $error("full pattern read with nibble bit set");
	a_cal_only_reads: assert property (cal_reg && is_cmd |-> is_rd || is_mrs)
		else $error("non-read command in pattern mode");
	a_lock_first: assert property (cal_reg && is_rd |-> up_reg >= 11'(ddr_pkg::DLL_LOCK_CYCLES))
		else $error("pattern read before lock");
	a_cmd_gap: assert property (is_cmd |=> !is_cmd [*2])
		else $error("commands too close");
	a_read_latency: assert property (rd_idle |-> ##1 !dq_dev_oe [*5] ##[1:2] $rose(dq_dev_oe))
		else $error("read latency wrong");
	a_full_burst: assert property ($rose(dq_dev_oe) && full_pend_reg |-> dq_dev_oe [*8] ##1 !dq_dev_oe)
		else $error("full burst length wrong");
	a_chop_burst: assert property ($rose(dq_dev_oe) && !full_pend_reg |-> dq_dev_oe [*4] ##1 !dq_dev_oe)
		else $error("chop burst length wrong");
	cover property (rd_idle && cal_reg && full_rd);
	cover property (rd_idle && cal_reg && !full_rd && addr[2]);
	cover property (is_mrs && ba == ddr_pkg::MR_SEL_THREE);
endmodule : ddr_link_assertions

// *** tb_sdram_cmd_decode_mpr_readout.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module tb_sdram_cmd_decode_mpr_readout;
	logic sys_clk_i, rstn_i, reg_wr_i, reg_rd_i, array_rd_o, self_refresh_o, cal_mode_o;
	logic [3:0] reg_addr_i, write_beats_o;
	logic [31:0] reg_wdata_i, reg_rdata_o, st;
	logic [15:0] array_data_i;
	logic [2:0] bank_o;
	logic [14:0] addr_o;
	ddr_pkg::cmd_e cmd_o, cap;
	int fails, n_tests;
	ddr_link_if link();
	ddr_device_end i_ddr_device_end (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link(link), .array_data_i(array_data_i),
		.array_rd_o(array_rd_o), .cmd_o(cmd_o), .bank_o(bank_o), .addr_o(addr_o), .write_beats_o(write_beats_o),
		.self_refresh_o(self_refresh_o), .cal_mode_o(cal_mode_o));
	ddr_ctrl_end i_ddr_ctrl_end (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link(link), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
	ddr_link_assertions i_ddr_link_assertions (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cke(link.cke),
		.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
		.addr(link.addr), .dq_dev(link.dq_dev), .dq_dev_oe(link.dq_dev_oe));
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : reg_rd
	task automatic issue(input ddr_pkg::cmd_e op, input logic [2:0] b, input logic [14:0] a);
		reg_wr(ddr_pkg::REG_ADDR, {17'h00000, a});
		reg_wr(ddr_pkg::REG_CMD, {25'h0000000, b, op});
		@(posedge sys_clk_i);
		#1 cap = cmd_o;
	endtask : issue
	task automatic cal_read(input logic [1:0] bl, input logic a12, input logic a2, input logic [7:0] pat);
		int n, f, k, i;
		logic [31:0] e;
		n = (bl == ddr_pkg::MODE0_BL_FIXED8 || (bl == ddr_pkg::MODE0_BL_FLY && a12)) ? 8 : 4;
		f = (n == 4 && a2) ? 4 : 0;
		e = 32'h00000000;
		i = 0;
		issue(ddr_pkg::CMD_MODE_SET, ddr_pkg::MR_SEL_ZERO, {13'h0000, bl});
		issue(ddr_pkg::CMD_RD, 3'h5, {2'h3, a12, 2'h3, 7'h7F, a2, 2'h3});
		`CHK("rd_cmd", ddr_pkg::CMD_RD, cap)
		`CHK("rd_low_addr", ((n == 8) ? 3'h0 : {a2, 2'h0}), addr_o[2:0])
		while (link.dq_dev_oe !== 1'b1 && i < 20) begin
			@(posedge sys_clk_i);
			#1 i++;
		end
		`CHK("rd_latency", ddr_pkg::READ_LATENCY + 1, i)
		`CHK("array_idle", 1'b0, array_rd_o)
		for (k = 0; k < n; k++) begin
			e[f + k] = pat[f + k];
			`CHK("beat", {16{pat[f + k]}}, link.dq)
			@(posedge sys_clk_i);
			#1;
		end
		`CHK("burst_end", 1'b0, link.dq_dev_oe)
		reg_rd(ddr_pkg::REG_RDATA, st);
		`CHK("rdata", e, st)
	endtask : cal_read
	task automatic t_lock();
		int i;
		i = 0;
		reg_rd(ddr_pkg::REG_STATUS, st);
		`CHK("lock_early", 1'b0, st[ddr_pkg::ST_DLL])
		issue(ddr_pkg::CMD_MODE_SET, ddr_pkg::MR_SEL_THREE, 15'h0004);
		`CHK("mode_set_cmd", ddr_pkg::CMD_MODE_SET, cap)
		issue(ddr_pkg::CMD_RD, 3'h0, 15'h0000);
		reg_rd(ddr_pkg::REG_STATUS, st);
		`CHK("rd_refused", 1'b1, st[ddr_pkg::ST_REFUSED])
		issue(ddr_pkg::CMD_ACT, 3'h0, 15'h0000);
		reg_rd(ddr_pkg::REG_STATUS, st);
		`CHK("act_refused", 1'b1, st[ddr_pkg::ST_REFUSED])
		`CHK("cal_on", 1'b1, cal_mode_o)
		while (st[ddr_pkg::ST_DLL] !== 1'b1 && i < 400) begin
			reg_rd(ddr_pkg::REG_STATUS, st);
			i++;
		end
		`CHK("lock_done", 1'b1, st[ddr_pkg::ST_DLL])
		$display("test lock done");
	endtask : t_lock
	task automatic t_pattern();
		cal_read(ddr_pkg::MODE0_BL_FIXED8, 1'b0, 1'b1, ddr_pkg::CAL_PATTERN);
		cal_read(ddr_pkg::MODE0_BL_FLY, 1'b1, 1'b0, ddr_pkg::CAL_PATTERN);
		cal_read(ddr_pkg::MODE0_BL_FLY, 1'b0, 1'b0, ddr_pkg::CAL_PATTERN);
		cal_read(ddr_pkg::MODE0_BL_FLY, 1'b0, 1'b1, ddr_pkg::CAL_PATTERN);
		cal_read(ddr_pkg::MODE0_BL_FIXED4, 1'b1, 1'b1, ddr_pkg::CAL_PATTERN);
		issue(ddr_pkg::CMD_MODE_SET, ddr_pkg::MR_SEL_THREE, 15'h0005);
		cal_read(ddr_pkg::MODE0_BL_FIXED8, 1'b0, 1'b0, {8{ddr_pkg::RESERVED_FILL}});
		issue(ddr_pkg::CMD_MODE_SET, ddr_pkg::MR_SEL_THREE, 15'h0000);
		@(posedge sys_clk_i);
		#1 `CHK("cal_off", 1'b0, cal_mode_o)
		$display("test pattern done");
	endtask : t_pattern
	task automatic t_decode();
		ddr_pkg::cmd_e ops[6] = '{ddr_pkg::CMD_ACT, ddr_pkg::CMD_WR, ddr_pkg::CMD_WR, ddr_pkg::CMD_PRE,
			ddr_pkg::CMD_PRE_ALL, ddr_pkg::CMD_REF};
		logic [14:0] ads[6] = '{15'h1234, 15'h0008, 15'h1015, 15'h0000, 15'h0400, 15'h0000};
		int i = 0;
		issue(ddr_pkg::CMD_MODE_SET, ddr_pkg::MR_SEL_ZERO, 15'h0001);
		for (int k = 0; k < 6; k++) begin
			issue(ops[k], 3'h2, ads[k]);
			`CHK("cmd", ops[k], cap)
			`CHK("cmd_addr", ads[k][9:0], addr_o[9:0])
			@(posedge sys_clk_i);
			#1;
			if (ops[k] == ddr_pkg::CMD_WR) begin
				`CHK("wbeats", (ads[k][12] ? ddr_pkg::BEATS_FULL : ddr_pkg::BEATS_CHOP), write_beats_o)
			end
		end
		// Ordinary read comes from the array side
		issue(ddr_pkg::CMD_RD, 3'h1, 15'h1000);
		`CHK("rd_bank", 3'h1, bank_o)
		while (link.dq_dev_oe !== 1'b1 && i < 20) begin
			@(posedge sys_clk_i);
			#1 i++;
		end
		`CHK("arr_latency", ddr_pkg::READ_LATENCY + 1, i)
		`CHK("array_rd", 1'b1, array_rd_o)
		`CHK("array_beat", array_data_i, link.dq)
		repeat (8) @(posedge sys_clk_i);
		$display("test decode done");
	endtask : t_decode
	task automatic t_self_ref();
		issue(ddr_pkg::CMD_SR_ENTER, 3'h0, 15'h0000);
		`CHK("sr_enter_cmd", ddr_pkg::CMD_SR_ENTER, cap)
		@(posedge sys_clk_i);
		#1 `CHK("sr_on", 1'b1, self_refresh_o)
		issue(ddr_pkg::CMD_SR_EXIT, 3'h0, 15'h0000);
		`CHK("sr_exit_cmd", ddr_pkg::CMD_SR_EXIT, cap)
		@(posedge sys_clk_i);
		#1 `CHK("sr_off", 1'b0, self_refresh_o)
		$display("test self refresh done");
	endtask : t_self_ref
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		rstn_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 4'h0;
		reg_wdata_i = 32'h00000000;
		array_data_i = 16'h5A3C;
		fails = 0;
		n_tests = 0;
		repeat (12) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		t_lock();
		t_pattern();
		t_decode();
		t_self_ref();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fails++;
		finish_test();
	end
endmodule : tb_sdram_cmd_decode_mpr_readout
